//--- design/asp_pkg.sv
/*
  Shared constants and types of the converter input-select and result-alignment block.
  Assumes a classic Wishbone slave port with 32-bit data and one word per parameter.
*/
package asp_pkg;

  // Parameter indices; the byte address is four times the index.
  localparam logic [7:0] IDX_ALIGN = 8'h06;
  localparam logic [7:0] IDX_PS1 = 8'h07;
  localparam logic [7:0] IDX_PS2 = 8'h08;
  localparam logic [7:0] IDX_PS3 = 8'h09;
  localparam logic [7:0] IDX_MISC = 8'h0C;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] IDX_RES_LO = 8'h21;
  localparam logic [7:0] IDX_RES_HI = 8'h22;

  // Field positions.
  localparam int unsigned IR_ALIGN_BIT = 5;
  localparam int unsigned VIS_ALIGN_BIT = 4;
  localparam int unsigned KIND_BIT = 2;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_BAD_BIT = 1;

  // Writable bits; reserved bits are held at zero.
  localparam logic [7:0] ALIGN_WMASK = 8'h30;
  localparam logic [7:0] MISC_WMASK = 8'h04;

  // Reset values.
  localparam logic [7:0] ALIGN_RST = 8'h00;
  localparam logic [7:0] PS1_RST = 8'h03;
  localparam logic [7:0] PS2_RST = 8'h03;
  localparam logic [7:0] PS3_RST = 8'h03;
  localparam logic [7:0] MISC_RST = 8'h04;

  // Converter input codes.
  localparam logic [7:0] SRC_SMALL_IR = 8'h00;
  localparam logic [7:0] SRC_VISIBLE = 8'h02;
  localparam logic [7:0] SRC_LARGE_IR = 8'h03;
  localparam logic [7:0] SRC_NONE = 8'h06;
  localparam logic [7:0] SRC_GND = 8'h25;
  localparam logic [7:0] SRC_TEMP = 8'h65;
  localparam logic [7:0] SRC_VDD = 8'h75;

  typedef enum logic [2:0] {
    CH_PS1,
    CH_PS2,
    CH_PS3,
    CH_VIS,
    CH_IR
  } asp_chan_e;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONVERT
  } asp_state_e;

  typedef struct packed {
    logic [7:0] align;
    logic [7:0] ps1;
    logic [7:0] ps2;
    logic [7:0] ps3;
    logic [7:0] misc;
  } asp_params_s;

  typedef struct packed {
    logic [7:0] source;
    logic led_en;
    logic low_bits;
    logic code_ok;
  } asp_setup_s;

  typedef struct packed {
    asp_state_e state;
    asp_params_s prm;
    logic bad_code;
    logic ack;
    logic [31:0] rdat;
    logic adc_start;
    logic [7:0] source;
    logic led_en;
    logic low_bits;
    logic [15:0] result;
    logic res_valid;
  } asp_regs_s;

endpackage

//--- design/asp_conv_setup.sv
/*
  Works out the converter input, LED permission and result cut for one measurement.
  Assumes the parameter set is stable while it is sampled; purely combinational.
*/
module asp_conv_setup (
  // Measurement request
  input wire asp_pkg::asp_chan_e chan_i,
  input wire asp_pkg::asp_params_s prm_i,
  // Resulting setup
  output asp_pkg::asp_setup_s setup_o
);

  function automatic logic code_ok(input logic [7:0] code, input logic normal);
    logic ok;
    ok = (code == asp_pkg::SRC_LARGE_IR) || (code == asp_pkg::SRC_SMALL_IR);
    if (!normal) begin
      ok = ok || (code == asp_pkg::SRC_VISIBLE) || (code == asp_pkg::SRC_NONE);
      ok = ok || (code == asp_pkg::SRC_GND) || (code == asp_pkg::SRC_TEMP);
      ok = ok || (code == asp_pkg::SRC_VDD);
    end
    return ok;
  endfunction

  logic normal;
  logic [7:0] code;
  logic prox;

  assign normal = prm_i.misc[asp_pkg::KIND_BIT];

  always_comb begin
    prox = 1'b1;
    case (chan_i)
      asp_pkg::CH_PS1: code = prm_i.ps1;
      asp_pkg::CH_PS2: code = prm_i.ps2;
      asp_pkg::CH_PS3: code = prm_i.ps3;
      asp_pkg::CH_VIS: begin
        code = asp_pkg::SRC_VISIBLE;
        prox = 1'b0;
      end
      default: begin
        code = asp_pkg::SRC_LARGE_IR;
        prox = 1'b0;
      end
    endcase
  end

  always_comb begin
    setup_o.source = code;
    // Ambient channels are always legal; their inputs are fixed here.
    setup_o.code_ok = prox ? code_ok(code, normal) : 1'b1;
    // Raw mode never lights an LED, whatever the LED selection says.
    setup_o.led_en = prox && normal;
    // Proximity alignment lives elsewhere, so proximity results keep the top bits.
    setup_o.low_bits = 1'b0;
    if (chan_i == asp_pkg::CH_VIS) begin
      setup_o.low_bits = prm_i.align[asp_pkg::VIS_ALIGN_BIT];
    end else if (chan_i == asp_pkg::CH_IR) begin
      setup_o.low_bits = prm_i.align[asp_pkg::IR_ALIGN_BIT];
    end
  end

endmodule

//--- design/asp_input_select.sv
/*
  Parameter store and conversion control for converter input select and result alignment.
  Assumes a classic Wishbone master, a sequencer that pulses a start with a channel, and a
  converter that pulses done with a 17-bit result.
*/
// Added by the designer: the Wishbone interface to the registers.
// Functional notes
// - Infrared ambient bit 5 set reports low 16 of 17 bits, else top 16.
// - Visible ambient bit 4 set reports low 16 of 17 bits, else top 16.
// - An 8-bit parameter picks the converter input for proximity channel one.
// - In normal proximity mode only codes 0x03 and 0x00 are valid.
// - Raw mode disables all LED drive and does unreferenced conversions.
// - Raw mode also accepts visible 0x02 and no-photodiode 0x06 codes.
// - Raw mode also accepts ground 0x25, temperature 0x65 and supply 0x75.
// - Channel two uses the same codes and resets to large infrared.
// - Channel three uses the same codes and mode dependence.
// - Conversion-kind bit 2 of the misc parameter, 1 means normal, resets 1.
module asp_input_select (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sequencer request
  input wire logic conv_start_i,
  input wire asp_pkg::asp_chan_e conv_chan_i,
  output logic busy_o,
  // Converter
  output logic adc_start_o,
  output logic [7:0] adc_source_o,
  output logic led_drive_en_o,
  input wire logic adc_done_i,
  input wire logic [16:0] adc_result_i,
  // Aligned result
  output logic [15:0] result_o,
  output logic result_valid_o
);

  function automatic logic [15:0] align_cut(input logic [16:0] raw, input logic low);
    logic [15:0] cut;
    cut = low ? raw[15:0] : raw[16:1];
    return cut;
  endfunction

  function automatic logic [7:0] masked(input logic [7:0] old, input logic [7:0] wr,
                                        input logic [7:0] mask);
    logic [7:0] val;
    val = (old & ~mask) | (wr & mask);
    return val;
  endfunction

  asp_pkg::asp_regs_s r;
  asp_pkg::asp_regs_s next_r;
  asp_pkg::asp_setup_s setup;
  logic [7:0] idx;
  logic req;
  logic wr_commit;
  logic wr_lane;
  logic [7:0] wbyte;
  logic clr_bad;
  logic [7:0] status;
  logic [31:0] rd_word;

  asp_conv_setup u_setup (
    .chan_i(conv_chan_i),
    .prm_i(r.prm),
    .setup_o(setup)
  );

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_lane = wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  // A write lands on the edge where the master sees ack, so it acts exactly once.
  assign wr_commit = req && wb_we_i && r.ack && wr_lane;

  always_comb begin
    status = 8'h00;
    status[asp_pkg::ST_BUSY_BIT] = (r.state == asp_pkg::ST_CONVERT);
    status[asp_pkg::ST_BAD_BIT] = r.bad_code;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (idx == asp_pkg::IDX_ALIGN) begin
      rd_word[7:0] = r.prm.align;
    end else if (idx == asp_pkg::IDX_PS1) begin
      rd_word[7:0] = r.prm.ps1;
    end else if (idx == asp_pkg::IDX_PS2) begin
      rd_word[7:0] = r.prm.ps2;
    end else if (idx == asp_pkg::IDX_PS3) begin
      rd_word[7:0] = r.prm.ps3;
    end else if (idx == asp_pkg::IDX_MISC) begin
      rd_word[7:0] = r.prm.misc;
    end else if (idx == asp_pkg::IDX_STATUS) begin
      rd_word[7:0] = status;
    end else if (idx == asp_pkg::IDX_RES_LO) begin
      rd_word[7:0] = r.result[7:0];
    end else if (idx == asp_pkg::IDX_RES_HI) begin
      rd_word[7:0] = r.result[15:8];
    end
  end

  assign clr_bad = wr_commit && (idx == asp_pkg::IDX_STATUS) && wbyte[asp_pkg::ST_BAD_BIT];

  always_comb begin
    next_r = r;
    next_r.adc_start = 1'b0;
    next_r.res_valid = 1'b0;

    // Bus side: ack one cycle after the request, then drop for a cycle.
    next_r.ack = req && !r.ack;
    if (req && !r.ack) begin
      next_r.rdat = rd_word;
    end

    // Parameter writes; unmapped addresses are acknowledged and ignored.
    if (wr_commit) begin
      if (idx == asp_pkg::IDX_ALIGN) begin
        // Reserved alignment bits stay zero even if the host sets them.
        next_r.prm.align = masked(r.prm.align, wbyte, asp_pkg::ALIGN_WMASK);
      end else if (idx == asp_pkg::IDX_PS1) begin
        next_r.prm.ps1 = wbyte;
      end else if (idx == asp_pkg::IDX_PS2) begin
        next_r.prm.ps2 = wbyte;
      end else if (idx == asp_pkg::IDX_PS3) begin
        next_r.prm.ps3 = wbyte;
      end else if (idx == asp_pkg::IDX_MISC) begin
        next_r.prm.misc = masked(r.prm.misc, wbyte, asp_pkg::MISC_WMASK);
      end
    end

    if (clr_bad) begin
      next_r.bad_code = 1'b0;
    end

    case (r.state)
      asp_pkg::ST_IDLE: begin
        // Parameters are sampled at start, so later writes cannot disturb a conversion.
        if (conv_start_i) begin
          next_r.state = asp_pkg::ST_CONVERT;
          next_r.adc_start = 1'b1;
          next_r.source = setup.source;
          next_r.led_en = setup.led_en;
          next_r.low_bits = setup.low_bits;
          // An illegal code still converts; the flag tells software it was wrong.
          if (!setup.code_ok) begin
            next_r.bad_code = 1'b1;
          end
        end
      end
      asp_pkg::ST_CONVERT: begin
        if (adc_done_i) begin
          next_r.state = asp_pkg::ST_IDLE;
          next_r.led_en = 1'b0;
          next_r.result = align_cut(adc_result_i, r.low_bits);
          next_r.res_valid = 1'b1;
        end
      end
      default: begin
        next_r.state = asp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.state <= asp_pkg::ST_IDLE;
      r.prm.align <= asp_pkg::ALIGN_RST;
      r.prm.ps1 <= asp_pkg::PS1_RST;
      r.prm.ps2 <= asp_pkg::PS2_RST;
      r.prm.ps3 <= asp_pkg::PS3_RST;
      r.prm.misc <= asp_pkg::MISC_RST;
      r.bad_code <= 1'b0;
      r.ack <= 1'b0;
      r.rdat <= 32'h0000_0000;
      r.adc_start <= 1'b0;
      r.source <= asp_pkg::SRC_LARGE_IR;
      r.led_en <= 1'b0;
      r.low_bits <= 1'b0;
      r.result <= 16'h0000;
      r.res_valid <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign busy_o = (r.state == asp_pkg::ST_CONVERT);
  assign adc_start_o = r.adc_start;
  assign adc_source_o = r.source;
  assign led_drive_en_o = r.led_en;
  assign result_o = r.result;
  assign result_valid_o = r.res_valid;

endmodule

//--- verification/asp_input_select_properties.sv
/*
  Port checker of the input-select block.
  Assumes it is bound into asp_input_select and that the host writes only listed codes.
*/
module asp_input_select_properties (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Conversion
  input wire logic conv_start_i,
  input wire asp_pkg::asp_chan_e conv_chan_i,
  input wire logic busy_o,
  input wire logic adc_start_o,
  input wire logic [7:0] adc_source_o,
  input wire logic led_drive_en_o,
  input wire logic adc_done_i,
  input wire logic [16:0] adc_result_i,
  input wire logic [15:0] result_o,
  input wire logic result_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Shadow copy of the parameters, built from completed bus writes.
  logic [7:0] src [3];
  logic [1:0] al;
  logic md;
  // Mode and cut as they stood at the accepted start, since the block latches them then.
  logic [1:0] als;
  logic mdl;
  logic [16:0] raw;
  asp_pkg::asp_chan_e ch;
  logic wr;
  logic px;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign px = ch inside {asp_pkg::CH_PS1, asp_pkg::CH_PS2, asp_pkg::CH_PS3};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src <= '{8'h03, 8'h03, 8'h03};
      al <= 2'h0;
      md <= 1'b1;
      als <= 2'h0;
      mdl <= 1'b1;
      ch <= asp_pkg::CH_PS1;
    end else begin
      if (wr && wb_adr_i[9:2] == 8'h06) al <= wb_dat_i[5:4];
      if (wr && wb_adr_i[9:2] == 8'h0C) md <= wb_dat_i[2];
      if (wr && wb_adr_i[9:2] inside {8'h07, 8'h08, 8'h09})
        src[2'(wb_adr_i[9:2] - 8'h07)] <= wb_dat_i[7:0];
      if (conv_start_i && !busy_o) begin
        ch <= conv_chan_i;
        als <= al;
        mdl <= md;
      end
    end
    if (busy_o && adc_done_i) raw <= adc_result_i;
  end
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus request not answered by a single ack");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_start_pulse: assert property (conv_start_i && !busy_o |=> adc_start_o && busy_o ##1 !adc_start_o)
    else $error("start not followed by one converter start");
  a_done_valid: assert property (busy_o && adc_done_i |=> result_valid_o && !busy_o && !led_drive_en_o)
    else $error("done not followed by valid result");
  a_prox_source: assert property (adc_start_o && px |-> adc_source_o == src[ch])
    else $error("wrong converter input");
  a_raw_no_led: assert property (!mdl |-> !led_drive_en_o)
    else $error("led driven in raw mode");
  a_led_normal: assert property (adc_start_o && px && mdl |-> led_drive_en_o)
    else $error("led not driven in normal mode");
  a_ir_cut: assert property (result_valid_o && ch == asp_pkg::CH_IR
    |-> result_o == (als[1] ? raw[15:0] : raw[16:1]))
    else $error("infrared result cut wrong");
  a_vis_cut: assert property (result_valid_o && ch == asp_pkg::CH_VIS
    |-> result_o == (als[0] ? raw[15:0] : raw[16:1]))
    else $error("visible result cut wrong");
  c_raw: cover property (adc_start_o && !md);
  c_ir_low: cover property (result_valid_o && ch == asp_pkg::CH_IR && al[1]);
  c_prox: cover property (adc_start_o && px && md);
endmodule

bind asp_input_select asp_input_select_properties u_props (.*);

//--- verification/asp_adc_model.sv
/*
  Converter model: answers each start after a chosen latency.
  Assumes the start pulse lasts one cycle.
*/
module asp_adc_model (
  // Clock and control
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [3:0] lat_i,
  input wire logic [16:0] val_i,
  // Converter answer
  output logic done_o,
  output logic [16:0] res_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  logic run = 1'b0;
  initial done_o = 1'b0;
  initial res_o = 17'h0;
  // The result toggles outside done so that a stale sample never matches.
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    res_o <= ~res_o;
    if (start_i) begin
      run <= 1'b1;
      cnt <= lat_i;
    end else if (run && cnt == 4'h0) begin
      run <= 1'b0;
      done_o <= 1'b1;
      res_o <= val_i;
    end else if (run) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

//--- verification/adc_input_select_align_params_tb_top.sv
/*
  Bench of the input-select block with a converter model.
  Assumes the hand-over timing of the bus and the conversion handshake.
*/
module adc_input_select_align_params_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [16:0] V = 17'h1ABCD;
  logic clk_i;
  logic rst_i = 1'b1, cyc = 1'b0, we = 1'b0, st = 1'b0;
  logic [9:0] adr = 10'h0;
  logic [31:0] wd = 32'h0, rd, dat;
  logic [3:0] lat = 4'h0;
  logic [3:0] sel = 4'h1;
  logic [16:0] val = 17'h0, raw;
  logic [15:0] res;
  logic [7:0] src;
  logic ack, busy, as, led, dn, vld;
  asp_pkg::asp_chan_e ch = asp_pkg::CH_PS1;
  int fails = 0, cmp_count = 0;
  logic [7:0] codes [7] = '{8'h02, 8'h03, 8'h00, 8'h06, 8'h25, 8'h65, 8'h75};
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  asp_input_select uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat),
    .wb_ack_o(ack), .conv_start_i(st), .conv_chan_i(ch), .busy_o(busy), .adc_start_o(as),
    .adc_source_o(src), .led_drive_en_o(led), .adc_done_i(dn), .adc_result_i(raw),
    .result_o(res), .result_valid_o(vld));
  asp_adc_model u_adc (.clk_i(clk_i), .start_i(as), .lat_i(lat), .val_i(val), .done_o(dn),
    .res_o(raw));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat;
    cyc <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] ix, input logic [31:0] exp);
    bus(1'b0, ix, 32'h0);
    chk(rd, exp);
  endtask
  // Latency steps up by three each time and wraps in four bits, so answers come both promptly and slowly.
  task automatic conv(input asp_pkg::asp_chan_e c, input logic [7:0] s, input logic l,
      input logic lo);
    @(posedge clk_i);
    st <= 1'b1;
    ch <= c;
    val <= V;
    lat <= lat + 4'h3;
    @(posedge clk_i);
    st <= 1'b0;
    #1;
    chk(src, s);
    chk(led, l);
    chk(busy, 1'b1);
    chk(as, 1'b1);
    do @(posedge clk_i); while (vld !== 1'b1);
    chk(res, lo ? V[15:0] : V[16:1]);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    fails++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h06, 32'h0);
    rdc(8'h07, 32'h3);
    rdc(8'h08, 32'h3);
    rdc(8'h09, 32'h3);
    rdc(8'h0C, 32'h4);
    rdc(8'h15, 32'h0);
    bus(1'b1, 8'h06, 32'hFF);
    rdc(8'h06, 32'h30);
    // A write without the low byte lane must leave the parameter alone.
    sel <= 4'h0;
    bus(1'b1, 8'h07, 32'h55);
    sel <= 4'h1;
    rdc(8'h07, 32'h3);
    $display("test registers done");
    conv(asp_pkg::CH_VIS, 8'h02, 1'b0, 1'b1);
    conv(asp_pkg::CH_IR, 8'h03, 1'b0, 1'b1);
    bus(1'b1, 8'h06, 32'h10);
    conv(asp_pkg::CH_VIS, 8'h02, 1'b0, 1'b1);
    conv(asp_pkg::CH_IR, 8'h03, 1'b0, 1'b0);
    $display("test alignment done");
    bus(1'b1, 8'h07, 32'h0);
    conv(asp_pkg::CH_PS1, 8'h00, 1'b1, 1'b0);
    conv(asp_pkg::CH_PS2, 8'h03, 1'b1, 1'b0);
    bus(1'b1, 8'h09, 32'h0);
    conv(asp_pkg::CH_PS3, 8'h00, 1'b1, 1'b0);
    $display("test normal mode done");
    bus(1'b1, 8'h0C, 32'h0);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, 8'(7 + i % 3), {24'h0, codes[i]});
      conv(asp_pkg::asp_chan_e'(i % 3), codes[i], 1'b0, 1'b0);
    end
    // The host takes separate reference conversions and reads them back over the bus.
    bus(1'b1, 8'h07, 32'h06);
    conv(asp_pkg::CH_PS1, 8'h06, 1'b0, 1'b0);
    rdc(8'h21, {24'h0, V[8:1]});
    rdc(8'h22, {24'h0, V[16:9]});
    bus(1'b1, 8'h08, 32'h25);
    conv(asp_pkg::CH_PS2, 8'h25, 1'b0, 1'b0);
    rdc(8'h21, {24'h0, V[8:1]});
    rdc(8'h22, {24'h0, V[16:9]});
    rdc(8'h20, 32'h0);
    bus(1'b1, 8'h0C, 32'h4);
    bus(1'b1, 8'h07, 32'h25);
    conv(asp_pkg::CH_PS1, 8'h25, 1'b1, 1'b0);
    rdc(8'h20, 32'h2);
    bus(1'b1, 8'h20, 32'h2);
    rdc(8'h20, 32'h0);
    $display("test raw mode done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h07, 32'h3);
    rdc(8'h06, 32'h0);
    rdc(8'h0C, 32'h4);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
